// ==== jtp_pkg.sv ====
// Notes on behaviour
// - mode 0: five 12-bit slots, tail, lanes paired
// - mode 1: three-lane pattern over two octets
// - mode 1: lane 2 dual/quad; C,D on 3-5
// - mode 2: one 8-bit sample per lane
// - mode 2: lanes 1-3 only where channel exists
// - mode 3: four 9-bit samples plus zero bit
// - tail bits and padding driven as zero
// - samples placed most significant bit first
// - lowest lanes used, higher lanes powered down
package jtp_pkg;
  localparam int LANES = 8;
  localparam int CHANS = 4;
  localparam int SAMP_W = 9;
  localparam int SAMP_PER_CH = 10;
  localparam int LANE_W = 64;
  localparam int WORD_W = CHANS * SAMP_PER_CH * SAMP_W;
  localparam int FIFO_DEPTH = 8;
  localparam int M0_SLOT_W = 12;
  localparam int M0_SLOTS = 5;
  localparam int M1_FRAME_W = 16;
  localparam int M2_FRAME_W = 8;
  localparam int M3_SLOT_W = 10;
  localparam int M3_SLOTS = 4;
  localparam int M1_LANES_GRP = 3;
  localparam logic [2:0] PAD3 = 3'h0;
  localparam logic [7:0] PAD_OCTET = 8'h00;
  localparam logic [3:0] TAIL4 = 4'h0;

  typedef enum logic [1:0] {
    JTP_MODE_0 = 2'h0,
    JTP_MODE_1 = 2'h1,
    JTP_MODE_2 = 2'h2,
    JTP_MODE_3 = 2'h3
  } jtp_mode_type;

  typedef enum logic [1:0] {
    JTP_PART_SINGLE = 2'h0,
    JTP_PART_DUAL = 2'h1,
    JTP_PART_QUAD = 2'h2
  } jtp_part_type;
endpackage : jtp_pkg

// ==== jtp_packer.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module jtp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_reg];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : AW'(wr_reg + 1'b1);
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : AW'(rd_reg + 1'b1);
      end
      cnt_reg <= (AW+1)'(cnt_reg + {AW'(0), push} - {AW'(0), pop});
    end
  end
endmodule : jtp_fifo

////////////////////////////////////////////////////////////////////////////
module jtp_packer import jtp_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // configuration
  input wire logic [1:0] link_mode_number,
  input wire logic [1:0] part_kind,
  // converter samples, one frame set per word
  input wire logic samp_valid,
  output logic samp_ready,
  input wire logic [WORD_W-1:0] samp_data,
  // lanes
  output logic lane_valid,
  input wire logic lane_ready,
  output logic [LANES*LANE_W-1:0] lane_data,
  output logic [LANES-1:0] lane_enable
);
  logic fifo_valid;
  logic [WORD_W-1:0] fifo_data;
  logic ld;
  logic valid_reg;
  logic [LANE_W-1:0] lane_reg [0:LANES-1];
  logic [LANE_W-1:0] lane_next [0:LANES-1];
  logic [LANES-1:0] en_reg;
  logic [LANES-1:0] en_next;
  jtp_mode_type mode_reg;
  jtp_part_type part_reg;

  function automatic logic [SAMP_W-1:0] samp(input logic [WORD_W-1:0] w,
                                             input int c, input int i);
    samp = w[(c*SAMP_PER_CH+i)*SAMP_W +: SAMP_W];
  endfunction : samp

  function automatic int lanes_used(input logic [1:0] m, input logic [1:0] p);
    int nch;
    nch = (p == JTP_PART_QUAD) ? 4 : ((p == JTP_PART_DUAL) ? 2 : 1);
    case (m)
      JTP_MODE_0: lanes_used = 2 * nch;
      JTP_MODE_1: lanes_used = (p == JTP_PART_QUAD) ? 6 :
                               ((p == JTP_PART_DUAL) ? 3 : 2);
      default: lanes_used = nch;
    endcase
  endfunction : lanes_used

  function automatic logic [LANE_W-1:0] pack_lane(input logic [WORD_W-1:0] w,
      input logic [1:0] m, input logic [1:0] p, input int l);
    logic [LANE_W-1:0] r;
    logic [SAMP_W-1:0] x0;
    logic [SAMP_W-1:0] x1;
    logic [SAMP_W-1:0] y0;
    logic [SAMP_W-1:0] y1;
    int g;
    r = '0;
    x0 = '0;
    x1 = '0;
    y0 = '0;
    y1 = '0;
    g = 0;
    if (l < lanes_used(m, p)) begin
      case (m)
        JTP_MODE_0: begin
          // tail nibble stays zero
          for (int i = 0; i < M0_SLOTS; i++) begin
            r[LANE_W-1-M0_SLOT_W*i -: M0_SLOT_W] =
              {samp(w, l / 2, 2 * i + (l % 2)), PAD3};
          end
        end
        JTP_MODE_1: begin
          g = l / M1_LANES_GRP;
          x0 = samp(w, 2 * g, 0);
          x1 = samp(w, 2 * g, 1);
          y0 = samp(w, 2 * g + 1, 0);
          y1 = samp(w, 2 * g + 1, 1);
          case (l % M1_LANES_GRP)
            0: r[LANE_W-1 -: M1_FRAME_W] = {x0, PAD3, x1[8:5]};
            1: r[LANE_W-1 -: M1_FRAME_W] = {x1[4:0], PAD3,
                 (p == JTP_PART_DUAL || p == JTP_PART_QUAD) ?
                 y0[8:1] : PAD_OCTET};
            default: r[LANE_W-1 -: M1_FRAME_W] = {y0[0], PAD3, y1, PAD3};
          endcase
        end
        JTP_MODE_2: begin
          x0 = samp(w, l, 0);
          r[LANE_W-1 -: M2_FRAME_W] = x0[SAMP_W-1:1];
        end
        default: begin
          for (int i = 0; i < M3_SLOTS; i++) begin
            r[LANE_W-1-M3_SLOT_W*i -: M3_SLOT_W] =
              {samp(w, l, i), 1'b0};
          end
        end
      endcase
    end
    pack_lane = r;
  endfunction : pack_lane

  ////////////////////////////////////////////////////////////////////////
  jtp_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .in_valid(samp_valid),
    .in_ready(samp_ready),
    .in_data(samp_data),
    .out_valid(fifo_valid),
    .out_ready(ld),
    .out_data(fifo_data)
  );

  // next frame loads when output is empty or being taken
  assign ld = fifo_valid & (~valid_reg | lane_ready);
  assign lane_valid = valid_reg;

  generate
    for (genvar l = 0; l < LANES; l++) begin : g_lane
      assign lane_next[l] = pack_lane(fifo_data, link_mode_number,
                                      part_kind, l);
      assign en_next[l] = (l < lanes_used(link_mode_number, part_kind));
      assign lane_data[l*LANE_W +: LANE_W] = lane_reg[l];

      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          lane_reg[l] <= '0;
        end else if (ld) begin
          lane_reg[l] <= lane_next[l];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      valid_reg <= 1'b0;
    end else if (ld) begin
      valid_reg <= 1'b1;
    end else if (lane_ready) begin
      valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      en_reg <= '0;
      mode_reg <= JTP_MODE_0;
      part_reg <= JTP_PART_SINGLE;
    end else if (ld) begin
      en_reg <= en_next;
      mode_reg <= jtp_mode_type'(link_mode_number);
      part_reg <= jtp_part_type'(part_kind);
    end
  end

  assign lane_enable = en_reg;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_load_mode(logic [1:0] m);
    ld && link_mode_number == m;
  endsequence

  a_mode0_slot: assert property (s_load_mode(JTP_MODE_0) |=>
    lane_data[LANE_W-1 -: SAMP_W] == $past(fifo_data[SAMP_W-1:0]))
    else $error("mode 0 lane 0 first slot wrong");
  a_tail_zero: assert property (valid_reg && mode_reg == JTP_MODE_0 |->
    lane_data[3:0] == TAIL4 && lane_data[54:52] == PAD3)
    else $error("mode 0 tail or pad not zero");
  a_mode1_pad: assert property (s_load_mode(JTP_MODE_1) |=>
    lane_data[54:52] == PAD3 && lane_data[47:0] == '0)
    else $error("mode 1 lane 0 padding wrong");
  a_mode1_single: assert property (valid_reg && mode_reg == JTP_MODE_1
    && part_reg == JTP_PART_SINGLE |-> lane_enable == 8'h03
    && lane_data[LANE_W+55 -: 8] == PAD_OCTET)
    else $error("mode 1 single part lanes wrong");
  a_mode2_lane1: assert property (ld && link_mode_number == JTP_MODE_2
    && (part_kind == JTP_PART_DUAL || part_kind == JTP_PART_QUAD) |=>
    lane_data[LANE_W+63 -: 8] ==
    $past(fifo_data[SAMP_PER_CH*SAMP_W+SAMP_W-1 -: M2_FRAME_W]))
    else $error("mode 2 lane 1 octet wrong");
  a_mode2_lanes: assert property (valid_reg && mode_reg == JTP_MODE_2
    && part_reg == JTP_PART_DUAL |-> lane_enable == 8'h03)
    else $error("mode 2 dual lane enables wrong");
  a_mode3_zero: assert property (valid_reg && mode_reg == JTP_MODE_3 |->
    !lane_data[54] && !lane_data[44] && !lane_data[34] && !lane_data[24])
    else $error("mode 3 pad bit set");
  a_lanes_low: assert property ((lane_enable &
    8'(lane_enable + 8'h01)) == 8'h00)
    else $error("lane enables not lowest contiguous");
  a_off_zero: assert property (valid_reg && !lane_enable[LANES-1] |->
    lane_data[LANES*LANE_W-1 -: LANE_W] == '0)
    else $error("disabled lane carries data");
  a_frame_hold: assert property (valid_reg && !lane_ready |=>
    valid_reg && $stable(lane_data) && $stable(lane_enable))
    else $error("frame changed while stalled");
endmodule : jtp_packer

// ==== jtp_lane_sink.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module jtp_lane_sink import jtp_pkg::*; (
  // clock
  input wire logic sys_clk,
  // lanes
  input wire logic lane_valid,
  output logic lane_ready,
  input wire logic [LANES-1:0] lane_enable,
  // control
  input wire logic stall,
  output int got
);
  assign lane_ready = !stall;
  initial got = 0;
  // only lane 0's enable gates the frame count
  always @(posedge sys_clk)
    if (lane_valid && lane_ready && lane_enable[0]) got <= got + 1;
endmodule : jtp_lane_sink

// ==== tb_top.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module tb_top import jtp_pkg::*;;
  logic sys_clk = 0, nrst = 0, samp_valid = 0, stall = 0;
  logic [1:0] mode = 2'h0, part = 2'h0;
  logic samp_ready, lane_valid, lane_ready;
  logic [WORD_W-1:0] word = '0;
  logic [LANES*LANE_W-1:0] lane_data, snap;
  logic [LANES-1:0] lane_enable;
  int n_fail = 0, num_checks = 0, got, k, g0;
  typedef struct { logic [1:0] m, p; logic [7:0] en; } jtp_row_type;
  jtp_row_type rows[14] = '{'{2'h0, 2'h0, 8'h03}, '{2'h0, 2'h1, 8'h0f},
    '{2'h0, 2'h2, 8'hff}, '{2'h1, 2'h0, 8'h03}, '{2'h1, 2'h1, 8'h07},
    '{2'h1, 2'h2, 8'h3f}, '{2'h2, 2'h0, 8'h01}, '{2'h2, 2'h1, 8'h03},
    '{2'h2, 2'h2, 8'h0f}, '{2'h3, 2'h0, 8'h01}, '{2'h3, 2'h1, 8'h03},
    '{2'h3, 2'h2, 8'h0f}, '{2'h3, 2'h3, 8'h01}, '{2'h1, 2'h3, 8'h03}};

  jtp_packer #(.DEPTH(FIFO_DEPTH)) u_jtp_packer (.sys_clk(sys_clk),
    .nrst(nrst), .link_mode_number(mode), .part_kind(part),
    .samp_valid(samp_valid), .samp_ready(samp_ready), .samp_data(word),
    .lane_valid(lane_valid), .lane_ready(lane_ready),
    .lane_data(lane_data), .lane_enable(lane_enable));
  jtp_lane_sink u_jtp_lane_sink (.sys_clk(sys_clk), .lane_valid(lane_valid),
    .lane_ready(lane_ready), .lane_enable(lane_enable), .stall(stall),
    .got(got));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [8:0] s(int c, int i);
    return 9'((c * 10 + i) * 37 + 5);
  endfunction : s

  function automatic logic [63:0] exp_lane(logic [1:0] m, logic [7:0] en,
                                           int l);
    int g;
    logic [8:0] x0, x1, y0, y1, t;
    logic [63:0] v;
    g = l / 3;
    x0 = s(2 * g, 0);
    x1 = s(2 * g, 1);
    y0 = s(2 * g + 1, 0);
    y1 = s(2 * g + 1, 1);
    t = s(l, 0);
    v = '0;
    if (m == 2'h0)
      for (int i = 0; i < 5; i++)
        v[63 - 12 * i -: 12] = {s(l / 2, 2 * i + l % 2), 3'h0};
    else if (m == 2'h1 && l % 3 == 0) v[63 -: 16] = {x0, 3'h0, x1[8:5]};
    else if (m == 2'h1 && l % 3 == 1)
      v[63 -: 16] = {x1[4:0], 3'h0, (en == 8'h03) ? 8'h00 : y0[8:1]};
    else if (m == 2'h1) v[63 -: 16] = {y0[0], 3'h0, y1, 3'h0};
    else if (m == 2'h2) v[63 -: 8] = t[8:1];
    else
      for (int i = 0; i < 4; i++)
        v[63 - 10 * i -: 10] = {s(l, i), 1'b0};
    return en[l] ? v : 64'h0;
  endfunction : exp_lane

  task automatic chk(logic [63:0] got_v, logic [63:0] exp_v);
    num_checks++;
    if (got_v !== exp_v) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  initial forever #10 sys_clk = ~sys_clk;

  initial begin
    #20000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    for (int c = 0; c < CHANS * SAMP_PER_CH; c++)
      word[c * 9 +: 9] = s(c / 10, c % 10);
    repeat (12) @(posedge sys_clk);
    #1 nrst = 1;
    foreach (rows[r]) begin
      mode = rows[r].m;
      part = rows[r].p;
      samp_valid = 1;
      @(posedge sys_clk);
      #1 samp_valid = 0;
      k = 0;
      while (lane_valid !== 1'b1 && k < 20) begin
        @(posedge sys_clk);
        #1 k++;
      end
      chk(64'(lane_enable), 64'(rows[r].en));
      for (int l = 0; l < LANES; l++)
        chk(lane_data[l * LANE_W +: LANE_W], exp_lane(mode, rows[r].en, l));
      $display("test mode %0d part %0d done", mode, part);
    end
    // last frame leaves, then fill while stalled; output stage holds one more
    @(posedge sys_clk);
    #1 stall = 1;
    samp_valid = 1;
    k = 0;
    repeat (12) begin
      if (samp_ready) k++;
      @(posedge sys_clk);
      #1;
    end
    samp_valid = 0;
    chk(64'(k), 64'(FIFO_DEPTH + 1));
    snap = lane_data;
    repeat (3) @(posedge sys_clk);
    #1 chk(lane_data[63:0], snap[63:0]);
    g0 = got;
    stall = 0;
    repeat (15) @(posedge sys_clk);
    #1 chk(64'(got - g0), 64'(k));
    chk(64'(lane_valid), 64'h0);
    $display("test fill and drain done");
    // reset in mid-stream
    stall = 1;
    samp_valid = 1;
    @(posedge sys_clk);
    #1 samp_valid = 0;
    @(posedge sys_clk);
    #1 nrst = 0;
    #1 chk(64'({lane_valid, lane_enable, samp_ready}), 64'h1);
    chk(lane_data[63:0], 64'h0);
    @(posedge sys_clk);
    #1 nrst = 1;
    stall = 0;
    samp_valid = 1;
    @(posedge sys_clk);
    #1 samp_valid = 0;
    @(posedge sys_clk);
    #1 chk(64'(lane_valid), 64'h1);
    chk(lane_data[63:0], exp_lane(mode, rows[13].en, 0));
    $display("test reset done");
    report_and_stop();
  end
endmodule : tb_top
